/* rtl/shc_defines.vh */
// constants for the sensor hub slot configuration and status block
// assumes word-wide register access; byte address is four times the index
`ifndef SHC_DEFINES_VH
`define SHC_DEFINES_VH

// register indices (byte address = index * 4)
`define SHC_IDX_S2_ADDR 8'h18
`define SHC_IDX_S2_TGT 8'h19
`define SHC_IDX_S2_CFG 8'h1A
`define SHC_IDX_S3_ADDR 8'h1B
`define SHC_IDX_S3_TGT 8'h1C
`define SHC_IDX_S3_CFG 8'h1D
`define SHC_IDX_S4_ADDR 8'h1E
`define SHC_IDX_S4_TGT 8'h1F
`define SHC_IDX_S4_CFG 8'h20
`define SHC_IDX_S1_WBYTE 8'h21
`define SHC_IDX_STATUS 8'h22
`define SHC_IDX_CTRL 8'h30
`define SHC_IDX_IRQ_STAT 8'h31
`define SHC_IDX_IRQ_MASK 8'h32

// address register fields
`define SHC_ADDR_RDEN_BIT 0
`define SHC_ADDR_MSB 7
`define SHC_ADDR_LSB 1

// config register fields
`define SHC_CFG_CNT_MSB 2
`define SHC_CFG_CNT_LSB 0
`define SHC_CFG_BATCH_BIT 3

// status register fields
`define SHC_ST_ENDOP_BIT 0
`define SHC_ST_NACK_LSB 3
`define SHC_ST_NACK_MSB 6
`define SHC_ST_WDONE_BIT 7

// control register fields
`define SHC_CTL_CNT_LSB 0
`define SHC_CTL_CNT_MSB 1
`define SHC_CTL_SWMODE_BIT 2
`define SHC_CTL_DIR_BIT 3

// interrupt status / mask fields
`define SHC_IRQ_ENDOP_BIT 0
`define SHC_IRQ_NACK_BIT 1
`define SHC_IRQ_WDONE_BIT 2
`define SHC_IRQ_W 3

// reset values
`define SHC_RST_BYTE 8'h00
`define SHC_RST_CFG 4'h0
`define SHC_RST_IRQ 3'h0
`define SHC_RST_CTRL 4'h0

`endif

/* rtl/shc_regs.v */
// sensor hub slot configuration and hub status, AHB-Lite register slave
// assumes the hub engine is on mclk_i and gives one-cycle event pulses
// reads take one wait state; writes finish in a single data phase
// event inputs share mclk_i, so they need no synchroniser
`timescale 1ns/1ps
`include "shc_defines.vh"

module shc_regs (
    input wire mclk_i,
    input wire rstn_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [31:0] hrdata_o,
    // hub engine events
    input wire cycle_start_i,
    input wire op_done_i,
    input wire write_done_i,
    input wire [3:0] noack_i,
    // configuration toward the hub engine
    output wire [7:0] sensor2_addr_o,
    output wire [7:0] sensor2_target_reg_field_o,
    output wire [3:0] sensor2_cfg_o,
    output wire [7:0] sensor3_addr_o,
    output wire [7:0] sensor3_target_o,
    output wire [3:0] sensor3_cfg_o,
    output wire [7:0] sensor4_addr_o,
    output wire [7:0] sensor4_target_o,
    output wire [3:0] sensor4_cfg_o,
    output reg [7:0] sensor1_write_value_o,
    output reg [1:0] sensor_count_select_o,
    output reg single_write_mode_o,
    output reg sensor1_dir_o,
    output reg [3:0] sensor_active_o,
    output reg sensor1_write_req_o,
    output reg irq_o
);

    // control reset word, taken apart field by field below
    localparam [3:0] CTRL_RST = `SHC_RST_CTRL;

    // address phase capture
    reg wr_pend_q;
    reg rd_pend_q;
    reg [7:0] idx_q;
    reg map_q;
    // status bits
    reg endop_q;
    reg [3:0] noack_q;
    reg wdone_q;
    // interrupts
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;

    // decoded strobes and read path
    wire accept;
    wire [7:0] wbyte;
    wire we_s2a;
    wire we_s2t;
    wire we_s2c;
    wire we_s3a;
    wire we_s3t;
    wire we_s3c;
    wire we_s4a;
    wire we_s4t;
    wire we_s4c;
    wire we_wb;
    wire we_ctl;
    wire we_ist;
    wire we_imk;
    wire [2:0] irq_evt;
    wire [7:0] status_byte;
    wire [7:0] ctrl_byte;
    reg [7:0] rd_byte;

    // only trans types nonseq/seq start a transfer; size is not checked
    assign accept = hsel_i & htrans_i[1] & hready_i;
    assign wbyte = hwdata_i[7:0];

    // write strobes during the data phase
    // status and unknown indices decode to no strobe, so writes drop
    assign we_s2a = wr_pend_q & map_q & (idx_q == `SHC_IDX_S2_ADDR);
    assign we_s2t = wr_pend_q & map_q & (idx_q == `SHC_IDX_S2_TGT);
    assign we_s2c = wr_pend_q & map_q & (idx_q == `SHC_IDX_S2_CFG);
    assign we_s3a = wr_pend_q & map_q & (idx_q == `SHC_IDX_S3_ADDR);
    assign we_s3t = wr_pend_q & map_q & (idx_q == `SHC_IDX_S3_TGT);
    assign we_s3c = wr_pend_q & map_q & (idx_q == `SHC_IDX_S3_CFG);
    assign we_s4a = wr_pend_q & map_q & (idx_q == `SHC_IDX_S4_ADDR);
    assign we_s4t = wr_pend_q & map_q & (idx_q == `SHC_IDX_S4_TGT);
    assign we_s4c = wr_pend_q & map_q & (idx_q == `SHC_IDX_S4_CFG);
    assign we_wb = wr_pend_q & map_q & (idx_q == `SHC_IDX_S1_WBYTE);
    assign we_ctl = wr_pend_q & map_q & (idx_q == `SHC_IDX_CTRL);
    assign we_ist = wr_pend_q & map_q & (idx_q == `SHC_IDX_IRQ_STAT);
    assign we_imk = wr_pend_q & map_q & (idx_q == `SHC_IDX_IRQ_MASK);

    // bus phase tracking; reads take one wait state so a write just
    // before them is already stored when the data is sampled
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= 8'h00;
            map_q <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h00000000;
        end
        else
        begin
            hresp_o <= 1'b0; // always okay
            // second read cycle: hand over the byte, end the wait
            if (rd_pend_q)
            begin
                hrdata_o <= {24'h000000, rd_byte};
                hreadyout_o <= 1'b1;
                rd_pend_q <= 1'b0;
            end
            else
            begin
                // address phases are only taken while no read waits
                wr_pend_q <= accept & hwrite_i;
                if (accept)
                begin
                    idx_q <= haddr_i[9:2];
                    map_q <= (haddr_i[31:10] == 22'h000000);
                end
                if (accept & ~hwrite_i)
                begin
                    rd_pend_q <= 1'b1;
                    hreadyout_o <= 1'b0;
                end
            end
        end
    end

    // three identical slots for sensors two to four
    // bit 0 of each address byte is that sensor's read enable
    shc_sensor_slot u_slot2 (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .addr_we_i(we_s2a),
        .tgt_we_i(we_s2t),
        .cfg_we_i(we_s2c),
        .wdata_i(wbyte),
        .addr_q_o(sensor2_addr_o),
        .tgt_q_o(sensor2_target_reg_field_o),
        .cfg_q_o(sensor2_cfg_o)
    );

    shc_sensor_slot u_slot3 (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .addr_we_i(we_s3a),
        .tgt_we_i(we_s3t),
        .cfg_we_i(we_s3c),
        .wdata_i(wbyte),
        .addr_q_o(sensor3_addr_o),
        .tgt_q_o(sensor3_target_o),
        .cfg_q_o(sensor3_cfg_o)
    );

    shc_sensor_slot u_slot4 (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .addr_we_i(we_s4a),
        .tgt_we_i(we_s4t),
        .cfg_we_i(we_s4c),
        .wdata_i(wbyte),
        .addr_q_o(sensor4_addr_o),
        .tgt_q_o(sensor4_target_o),
        .cfg_q_o(sensor4_cfg_o)
    );

    // sensor one write byte and hub control bits
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sensor1_write_value_o <= `SHC_RST_BYTE;
            sensor_count_select_o <=
                CTRL_RST[`SHC_CTL_CNT_MSB:`SHC_CTL_CNT_LSB];
            single_write_mode_o <= CTRL_RST[`SHC_CTL_SWMODE_BIT];
            sensor1_dir_o <= CTRL_RST[`SHC_CTL_DIR_BIT];
        end
        else
        begin
            if (we_wb)
                sensor1_write_value_o <= wbyte;
            // all control fields land together from one write
            if (we_ctl)
            begin
                sensor_count_select_o <=
                    wbyte[`SHC_CTL_CNT_MSB:`SHC_CTL_CNT_LSB];
                single_write_mode_o <= wbyte[`SHC_CTL_SWMODE_BIT];
                sensor1_dir_o <= wbyte[`SHC_CTL_DIR_BIT];
            end
        end
    end

    // which sensors the engine services, and whether sensor one writes;
    // a read-enabled slot outside the selected count stays idle
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sensor_active_o <= 4'h0;
            sensor1_write_req_o <= 1'b0;
        end
        else
        begin
            // sensor one is serviced in every hub cycle
            sensor_active_o[0] <= 1'b1;
            sensor_active_o[1] <= (sensor_count_select_o >= 2'b01) &
                sensor2_addr_o[`SHC_ADDR_RDEN_BIT];
            sensor_active_o[2] <= (sensor_count_select_o >= 2'b10) &
                sensor3_addr_o[`SHC_ADDR_RDEN_BIT];
            sensor_active_o[3] <= (sensor_count_select_o == 2'b11) &
                sensor4_addr_o[`SHC_ADDR_RDEN_BIT];
            // write each cycle while sensor1_dir_o is low, unless the single write is already done
            sensor1_write_req_o <= ~sensor1_dir_o &
                ~(single_write_mode_o & wdone_q);
        end
    end

    // hub status; hardware sets win over the cycle-start clear
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            endop_q <= 1'b0;
            noack_q <= 4'h0;
            wdone_q <= 1'b0;
        end
        else
        begin
            // end of operation holds until the next cycle starts
            if (op_done_i)
                endop_q <= 1'b1;
            else if (cycle_start_i)
                endop_q <= 1'b0;
            // a flag raised in the clearing cycle survives the clear
            noack_q <= noack_i | (cycle_start_i ? 4'h0 : noack_q);
            // done only counts in single write mode; leaving it re-arms
            if (single_write_mode_o & write_done_i & ~sensor1_dir_o)
                wdone_q <= 1'b1;
            else if (~single_write_mode_o)
                wdone_q <= 1'b0;
        end
    end

    // packed status view; bits between end-of-op and flags read zero
    assign status_byte[`SHC_ST_ENDOP_BIT] = endop_q;
    assign status_byte[`SHC_ST_NACK_LSB-1:`SHC_ST_ENDOP_BIT+1] = 2'b00;
    assign status_byte[`SHC_ST_NACK_MSB:`SHC_ST_NACK_LSB] = noack_q;
    assign status_byte[`SHC_ST_WDONE_BIT] = wdone_q;

    // control readback, same layout as the write
    assign ctrl_byte[`SHC_CTL_CNT_MSB:`SHC_CTL_CNT_LSB] =
        sensor_count_select_o;
    assign ctrl_byte[`SHC_CTL_SWMODE_BIT] = single_write_mode_o;
    assign ctrl_byte[`SHC_CTL_DIR_BIT] = sensor1_dir_o;
    assign ctrl_byte[7:`SHC_CTL_DIR_BIT+1] = 4'h0;

    // interrupt events: rising of each status source
    // events are edges, so a flag that stays set raises no new one
    assign irq_evt[`SHC_IRQ_ENDOP_BIT] = op_done_i & ~endop_q;
    assign irq_evt[`SHC_IRQ_NACK_BIT] = |(noack_i & ~noack_q);
    assign irq_evt[`SHC_IRQ_WDONE_BIT] = single_write_mode_o &
        write_done_i & ~sensor1_dir_o & ~wdone_q;

    // sticky interrupt status, write one to clear, set wins
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_stat_q <= `SHC_RST_IRQ;
            irq_mask_q <= `SHC_RST_IRQ;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_evt |
                (irq_stat_q & ~(we_ist ? wbyte[2:0] : 3'b000));
            if (we_imk)
                irq_mask_q <= wbyte[2:0];
            // level output, one cycle behind the status and mask
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read mux; status is read only, unmapped reads as zero
    // unstored config bits and gaps in the map read back as zero
    always @*
    begin
        rd_byte = 8'h00;
        if (map_q)
        begin
            case (idx_q)
                `SHC_IDX_S2_ADDR: rd_byte = sensor2_addr_o;
                `SHC_IDX_S2_TGT: rd_byte = sensor2_target_reg_field_o;
                `SHC_IDX_S2_CFG: rd_byte = {4'h0, sensor2_cfg_o};
                `SHC_IDX_S3_ADDR: rd_byte = sensor3_addr_o;
                `SHC_IDX_S3_TGT: rd_byte = sensor3_target_o;
                `SHC_IDX_S3_CFG: rd_byte = {4'h0, sensor3_cfg_o};
                `SHC_IDX_S4_ADDR: rd_byte = sensor4_addr_o;
                `SHC_IDX_S4_TGT: rd_byte = sensor4_target_o;
                `SHC_IDX_S4_CFG: rd_byte = {4'h0, sensor4_cfg_o};
                `SHC_IDX_S1_WBYTE: rd_byte = sensor1_write_value_o;
                `SHC_IDX_STATUS: rd_byte = status_byte;
                `SHC_IDX_CTRL: rd_byte = ctrl_byte;
                `SHC_IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat_q};
                `SHC_IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
                default: rd_byte = 8'h00;
            endcase
        end
    end

endmodule // shc_regs

/* rtl/shc_sensor_slot.v */
// one configuration slot: bus address, target register and read config
// assumes write strobes arrive one cycle wide from the bus slave
`timescale 1ns/1ps
`include "shc_defines.vh"

module shc_sensor_slot (
    input wire mclk_i,
    input wire rstn_i,
    input wire addr_we_i,
    input wire tgt_we_i,
    input wire cfg_we_i,
    input wire [7:0] wdata_i,
    output reg [7:0] addr_q_o,
    output reg [7:0] tgt_q_o,
    output reg [3:0] cfg_q_o
);

    // plain storage; upper config nibble is never kept
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            addr_q_o <= `SHC_RST_BYTE;
            tgt_q_o <= `SHC_RST_BYTE;
            cfg_q_o <= `SHC_RST_CFG;
        end
        else
        begin
            if (addr_we_i)
                addr_q_o <= wdata_i;
            if (tgt_we_i)
                tgt_q_o <= wdata_i;
            if (cfg_we_i)
                cfg_q_o <= wdata_i[3:0];
        end
    end

endmodule // shc_sensor_slot

/* testbench/sensor_hub_slave_config_status_tb.sv */
// self-checking bench for the hub register slave
// drives the ahb-lite side and the hub engine model; one clock
`timescale 1ns/1ps
`include "shc_defines.vh"
module sensor_hub_slave_config_status_tb;
    reg mclk, rstn, hsel, hwrite, go;
    reg [31:0] haddr, hwdata, rd;
    reg [1:0] htrans;
    reg [3:0] nack;
    wire hrdy, hresp, wreq, irq, cs, od, wd, swm, dir, busy;
    wire [31:0] hrdata;
    wire [3:0] noack, s2c, s3c, s4c, act;
    wire [7:0] s2a, s2t, s3a, s3t, s4a, s4t, wval;
    wire [1:0] cnt;
    integer errors, comparisons, i;
    // ready loops back: the slave is alone on the bus
    shc_regs dut (.mclk_i(mclk), .rstn_i(rstn), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
        .cycle_start_i(cs), .op_done_i(od), .write_done_i(wd),
        .noack_i(noack), .sensor2_addr_o(s2a),
        .sensor2_target_reg_field_o(s2t), .sensor2_cfg_o(s2c),
        .sensor3_addr_o(s3a), .sensor3_target_o(s3t),
        .sensor3_cfg_o(s3c), .sensor4_addr_o(s4a),
        .sensor4_target_o(s4t), .sensor4_cfg_o(s4c),
        .sensor1_write_value_o(wval), .sensor_count_select_o(cnt),
        .single_write_mode_o(swm), .sensor1_dir_o(dir),
        .sensor_active_o(act), .sensor1_write_req_o(wreq), .irq_o(irq));
    shc_hub_model hub_m (.mclk_i(mclk), .rstn_i(rstn), .go_i(go),
        .nack_i(nack), .write_req_i(wreq), .cycle_start_o(cs),
        .op_done_o(od), .write_done_o(wd), .noack_o(noack),
        .busy_o(busy));
    // 100 mhz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function [31:0] ba(input [7:0] idx);
        ba = {22'h0, idx, 2'h0};
    endfunction
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp)
            begin
                errors = errors + 1;
                $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // one single transfer; waits on hready, no fixed latency
    task bus(input w, input [31:0] a, input [7:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            @(posedge mclk);
            while (hrdy !== 1'b1) @(posedge mclk);
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            @(posedge mclk);
            while (hrdy !== 1'b1) @(posedge mclk);
            rd = hrdata;
        end
    endtask
    task rdchk(input string nm, input [31:0] a, input [31:0] exp);
        begin
            bus(1'b0, a, 8'h00);
            chk(nm, rd, exp);
        end
    endtask
    // one full hub cycle, then time for the status to settle
    task hub(input [3:0] n);
        begin
            nack <= n;
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            @(posedge mclk);
            while (busy === 1'b1) @(posedge mclk);
            repeat (3) @(posedge mclk);
        end
    endtask
    task t_reset;
        begin
            for (i = 24; i <= 34; i = i + 1)
                rdchk("rst", ba(i[7:0]), 0);
            chk("act", act, 4'h1);
            chk("irq", irq, 1'b0);
        end
    endtask
    task t_slots;
        reg [7:0] v;
        begin
            for (i = 24; i <= 33; i = i + 1)
            begin
                v = (i % 3 == 2) ? 8'h0D : {i[3:0], ~i[3:0]};
                bus(1'b1, ba(i[7:0]), v);
                rdchk("slot", ba(i[7:0]), v);
            end
            chk("s2a", s2a, 8'h87);
            chk("s2t", s2t, 8'h96);
            chk("s3a", s3a, 8'hB4);
            chk("s3c", s3c, 4'hD);
            chk("s4a", s4a, 8'hE1);
            chk("s4c", s4c, 4'hD);
            chk("s3t", s3t, 8'hC3);
            chk("s4t", s4t, 8'hF0);
            chk("s2c", s2c, 4'hD);
            chk("wval", wval, 8'h1E);
        end
    endtask
    // sensor three has reads disabled, so its slot stays idle
    task t_count;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                bus(1'b1, ba(`SHC_IDX_CTRL), i[7:0]);
                repeat (2) @(posedge mclk);
                chk("act", act, {i == 3, 1'b0, i > 0, 1'b1});
                chk("cnt", cnt, i[1:0]);
            end
        end
    endtask
    task t_hub;
        begin
            bus(1'b1, ba(`SHC_IDX_CTRL), 8'h00);
            hub(4'h2);
            rdchk("sts", ba(`SHC_IDX_STATUS), 8'h11);
            hub(4'h0);
            rdchk("sts", ba(`SHC_IDX_STATUS), 8'h01);
            bus(1'b1, ba(`SHC_IDX_STATUS), 8'hFF);
            rdchk("sts", ba(`SHC_IDX_STATUS), 8'h01);
            rdchk("hole", 32'h400, 0);
        end
    endtask
    task t_once;
        begin
            bus(1'b1, ba(`SHC_IDX_CTRL), 8'h04);
            hub(4'h0);
            rdchk("sts", ba(`SHC_IDX_STATUS), 8'h81);
            chk("wreq", wreq, 1'b0);
            chk("swm", swm, 1'b1);
            bus(1'b1, ba(`SHC_IDX_CTRL), 8'h08);
            repeat (2) @(posedge mclk);
            chk("wreq", wreq, 1'b0);
            chk("dir", dir, 1'b1);
            bus(1'b1, ba(`SHC_IDX_CTRL), 8'h00);
            repeat (2) @(posedge mclk);
            chk("wreq", wreq, 1'b1);
            rdchk("sts", ba(`SHC_IDX_STATUS), 8'h01);
        end
    endtask
    task t_irq;
        begin
            bus(1'b1, ba(`SHC_IDX_IRQ_STAT), 8'h07);
            bus(1'b1, ba(`SHC_IDX_IRQ_MASK), 8'h01);
            repeat (3) @(posedge mclk);
            chk("irq", irq, 1'b0);
            hub(4'h0);
            chk("irq", irq, 1'b1);
            rdchk("isr", ba(`SHC_IDX_IRQ_STAT), 8'h01);
            bus(1'b1, ba(`SHC_IDX_IRQ_STAT), 8'h01);
            repeat (3) @(posedge mclk);
            chk("irq", irq, 1'b0);
            bus(1'b1, ba(`SHC_IDX_IRQ_MASK), 8'h00);
            hub(4'h0);
            chk("irq", irq, 1'b0);
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d comparisons %0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // main sequence after a six-cycle reset
    initial
    begin
        errors = 0;
        comparisons = 0;
        {rstn, hsel, hwrite, go, haddr, hwdata, htrans, nack} = 0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_slots;
        t_count;
        t_hub;
        t_once;
        t_irq;
        stop_test;
    end
    // watchdog, far beyond the few hundred cycles needed
    initial
    begin
        #200000;
        errors = errors + 1;
        stop_test;
    end
endmodule // sensor_hub_slave_config_status_tb

/* testbench/shc_hub_model.sv */
// hub engine model: one cycle of start, write, reads, end
// assumes a one-cycle go pulse from the bench while idle
`timescale 1ns/1ps
module shc_hub_model (
    input wire mclk_i,
    input wire rstn_i,
    input wire go_i,
    input wire [3:0] nack_i,
    input wire write_req_i,
    output reg cycle_start_o,
    output reg op_done_o,
    output reg write_done_o,
    output reg [3:0] noack_o,
    output wire busy_o
);
    reg [3:0] step_q;
    assign busy_o = step_q != 4'h0;
    // sequence steps; every event is a one-cycle pulse
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            step_q <= 4'h0;
            cycle_start_o <= 1'b0;
            op_done_o <= 1'b0;
            write_done_o <= 1'b0;
            noack_o <= 4'h0;
        end
        else
        begin
            if (step_q == 4'h8)
                step_q <= 4'h0;
            else if (busy_o || go_i)
                step_q <= step_q + 4'h1;
            cycle_start_o <= go_i && !busy_o;
            write_done_o <= step_q == 4'h3 && write_req_i;
            noack_o <= (step_q == 4'h5) ? nack_i : 4'h0;
            op_done_o <= step_q == 4'h7;
        end
    end
endmodule // shc_hub_model

/* testbench/shc_regs_properties.sv */
// checker for the hub register slave, sees only its ports
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`include "shc_defines.vh"
module shc_regs_properties (
    input wire mclk_i,
    input wire rstn_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [31:0] hrdata_o,
    input wire [7:0] sensor2_addr_o,
    input wire [3:0] sensor2_cfg_o,
    input wire [7:0] sensor4_target_o,
    input wire [1:0] sensor_count_select_o,
    input wire sensor1_dir_o,
    input wire [3:0] sensor_active_o,
    input wire sensor1_write_req_o
);
    localparam logic [31:0] A_CFG2 = {22'h0, `SHC_IDX_S2_CFG, 2'h0};
    localparam logic [31:0] A_TGT4 = {22'h0, `SHC_IDX_S4_TGT, 2'h0};
    // a transfer is taken when its address phase meets hready
    wire take = hsel_i & htrans_i[1] & hready_i;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    AST_RD_WAIT: assert property (take & !hwrite_i |=> !hreadyout_o ##1
        hreadyout_o) else $error("read wait state wrong");
    AST_WR_NOWAIT: assert property (take & hwrite_i |=> hreadyout_o)
        else $error("write data phase stalled");
    AST_OKAY: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    AST_RD_HI: assert property ($rose(hreadyout_o) |->
        hrdata_o[31:8] == 24'h0) else $error("read upper bits set");
    AST_CFG_WR: assert property (
        take & hwrite_i & haddr_i == A_CFG2 |->
        ##2 sensor2_cfg_o == $past(hwdata_i[3:0]))
        else $error("slot two config not stored");
    AST_TGT4_WR: assert property (
        take & hwrite_i & haddr_i == A_TGT4 |->
        ##2 sensor4_target_o == $past(hwdata_i[7:0]))
        else $error("slot four target not stored");
    AST_ACT1: assert property (sensor_active_o[1] ==
        $past(sensor_count_select_o != 2'h0 && sensor2_addr_o[0]))
        else $error("slot two activity wrong");
    AST_DIR_RD: assert property (sensor1_dir_o |=> !sensor1_write_req_o)
        else $error("write requested in read mode");
    // main scenarios seen
    cover property (take & !hwrite_i);
    cover property (take & hwrite_i & haddr_i == A_CFG2);
    cover property ($fell(sensor1_write_req_o));
endmodule // shc_regs_properties
bind shc_regs shc_regs_properties chk (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hready_i(hready_i),
    .hwdata_i(hwdata_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .hrdata_o(hrdata_o),
    .sensor2_addr_o(sensor2_addr_o),
    .sensor2_cfg_o(sensor2_cfg_o),
    .sensor4_target_o(sensor4_target_o),
    .sensor_count_select_o(sensor_count_select_o),
    .sensor1_dir_o(sensor1_dir_o),
    .sensor_active_o(sensor_active_o),
    .sensor1_write_req_o(sensor1_write_req_o)
);
